// file: bench/sram_jtag_tap_test.sv
module sram_jtag_tap_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, extest_o, q_oe_o;
    logic [108:0] ring_i = '0;
    logic [108:0] ring_o, din, dout, pre, ex, msk;
    logic [31:0] seed = 32'haf46_77a6;
    logic [2:0] c;
    logic [2:0] ins [5] = '{stp_pkg::INS_SAMPLE, stp_pkg::INS_EXTEST,
        stp_pkg::INS_SAMPLE_Z, stp_pkg::INS_BYPASS, stp_pkg::INS_IDENT};
    logic [31:0] id = {stp_pkg::ID_VERSION, stp_pkg::ID_PART,
        stp_pkg::ID_VENDOR, stp_pkg::ID_PRESENT};
    int n, num_errors = 0, samples_checked = 0, cycles = 0;
    stp_tap dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .tck_i(tck_i),
        .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .ring_i(ring_i), .ring_o(ring_o), .extest_o(extest_o),
        .q_oe_o(q_oe_o));
    stp_ctl_model ctl_u (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
        .tdo_i(tdo_o));
    // core clock and run limit
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
    // random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction
    task automatic rnd(output logic [108:0] v);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            v = {v[76:0], seed};
        end
    endtask
    // compare one result
    task automatic check(input logic [108:0] got, input logic [108:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // scan and settle on a falling core edge
    task automatic scan(input logic ir, input int len, input logic [108:0] d);
        @(negedge core_clk_i);
        ctl_u.scan(ir, len, d, dout);
        @(negedge core_clk_i);
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(negedge core_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        ctl_u.reset_tap();
        pre = {1'b1, 108'h0};
        check(ring_o, pre);
        check(q_oe_o, 1'b1);
        check(tdo_oe_o, 1'b0);
        scan(1'b0, 32, '0);
        check(dout, id);
        for (int r = 0; r < 10; r++) begin
            c = ins[r % 5];
            scan(1'b1, 3, {106'h0, c});
            check(dout, stp_pkg::IR_CAPTURE);
            check(extest_o, c == stp_pkg::INS_EXTEST);
            rnd(ring_i);
            rnd(din);
            n = c == stp_pkg::INS_IDENT ? 32 :
                c == stp_pkg::INS_BYPASS ? 8 : 109;
            msk = ~('1 << n);
            ex = c == stp_pkg::INS_IDENT ? id :
                c == stp_pkg::INS_BYPASS ? {din[107:0], 1'b0} : ring_i;
            scan(1'b0, n, din);
            check(dout, ex & msk);
            pre = n == 109 ? din : pre;
            check(ring_o, pre);
            check(q_oe_o, c == stp_pkg::INS_SAMPLE_Z ? 1'b0 :
                c == stp_pkg::INS_EXTEST ? pre[108] : 1'b1);
            check(tdo_oe_o, 1'b0);
        end
        // mid-run controller reset out of external test
        scan(1'b1, 3, {106'h0, stp_pkg::INS_EXTEST});
        check(extest_o, 1'b1);
        ctl_u.reset_tap();
        check(extest_o, 1'b0);
        check(ring_o[108], 1'b1);
        check(q_oe_o, 1'b1);
        check(tdo_oe_o, 1'b0);
        scan(1'b0, 32, '0);
        check(dout, id);
        give_verdict();
    end
endmodule // sram_jtag_tap_test

// file: bench/stp_ctl_model.sv
module stp_ctl_model (
    // test pins
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // test clock stands low between frames
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // one test clock: pins set while low, serial out read before rise
    task automatic clk(input logic ms, input logic di, output logic dq);
        tms_o = ms;
        tdi_o = di;
        #31.0;
        dq = tdo_i;
        tck_o = 1'b1;
        #62.5;
        tck_o = 1'b0;
        #31.5;
    endtask
    // idle to shift, len bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int len,
        input logic [108:0] d, output logic [108:0] q);
        logic b;
        q = '0;
        #2.0; // keeps pin edges off the core rising edge
        clk(1'b1, 1'b0, b);
        if (ir) clk(1'b1, 1'b0, b);
        clk(1'b0, 1'b0, b);
        clk(1'b0, 1'b0, b);
        for (int i = 0; i < len; i++) begin
            clk(i == len - 1, d[i], b);
            q[i] = b;
        end
        clk(1'b1, 1'b0, b);
        clk(1'b0, 1'b0, b);
    endtask
    // five clocks with mode select high, then idle
    task automatic reset_tap();
        logic b;
        #2.0; // keeps pin edges off the core rising edge
        repeat (5) clk(1'b1, 1'b0, b);
        clk(1'b0, 1'b0, b);
    endtask
endmodule // stp_ctl_model

// file: bench/stp_tap_props.sv
module stp_tap_props (
    // clock, reset and test clock pin
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic tck_i,
    // outputs watched
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [stp_pkg::BSR_W-1:0] ring_o,
    input wire logic extest_o,
    input wire logic q_oe_o
);
    logic [4:0] tck_reg, tck_next;
    logic fwin, rwin;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // history of the sampled test clock
    always_comb tck_next = {tck_reg[3:0], tck_i};
    always_ff @(posedge core_clk_i) tck_reg <= tck_next;
    // a test clock fall or rise two to five cycles back
    assign fwin = tck_reg[4] & ~tck_reg[1];
    assign rwin = ~tck_reg[4] & tck_reg[1];
    a_reset_outputs: assert property ($fell(srst_i) |-> !tdo_oe_o
        && q_oe_o && ring_o[108] && !extest_o) else $error("reset state");
    a_qoe_extest: assert property (extest_o |-> q_oe_o == ring_o[108])
        else $error("output enable not cell 108");
    a_tdo_on_fall: assert property ($changed(tdo_o) |-> fwin)
        else $error("serial out moved off falling edge");
    a_oe_on_fall: assert property ($changed(tdo_oe_o) |-> fwin)
        else $error("serial enable moved off falling edge");
    a_tdo_holds: assert property (
        $changed(tdo_o) |=> $stable(tdo_o) [*8])
        else $error("serial out not held");
    a_ring_on_rise: assert property ($changed(ring_o) |-> rwin)
        else $error("latches moved off rising edge");
    a_mode_on_rise: assert property ($changed(extest_o) |-> rwin)
        else $error("mode moved off rising edge");
    a_qoe_on_rise: assert property ($changed(q_oe_o) |-> rwin)
        else $error("output enable moved off rising edge");
endmodule // stp_tap_props

bind stp_tap stp_tap_props chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ring_o(ring_o),
    .extest_o(extest_o), .q_oe_o(q_oe_o));

// file: inc/stp_pkg.sv
package stp_pkg;
    // ------------------------------------------------------------
    // register sizes
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 109;
    localparam int BSR_OE_BIT = 108;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDENT = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // ------------------------------------------------------------
    // identification fields, values arbitrary
    // ------------------------------------------------------------
    localparam logic [2:0] ID_VERSION = 3'h0;
    localparam logic [16:0] ID_PART = 17'h0_1234;
    localparam logic [10:0] ID_VENDOR = 11'h055;
    localparam logic ID_PRESENT = 1'b1;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } stp_state_t;
endpackage

// file: src/stp_sync.sv
// ----------------------------------------------------------------
// two flip-flop synchroniser for the test pins and the pin ring
// ----------------------------------------------------------------
module stp_sync #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // pins
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // stage next values
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    // stage registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule // stp_sync

// file: src/stp_tap.sv
// Contract
// RL1: state advances on each rising test clock, following the mode select.
// RL2: identify code captures the 32-bit id word and scans it.
// RL3: high-z sample captures pins, scans chain, floats memory outputs.
// RL4: sample/preload captures pins into 109-bit chain, no memory effect.
// RL5: bypass code puts the one-bit bypass cell in the scan path.
// RL6: all-zero code is external test, capturing the pin ring.
// RL7: tester never loads the three reserved codes.
// RL8: id word: version top three bits, part field, vendor field.
// RL9: id word bit zero always reads one.
// RL10: reset state and power-up load the identify instruction.
// RL11: capture-instruction loads binary 01 into the low two cells.
// RL12: sample input on rising clock, change output on falling clock.
// RL13: cell 108 in external test drives outputs when one, floats when zero.
// RL14: controller follows the standard sixteen-state sequence.
module stp_tap (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // test pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // pin ring
    input wire logic [stp_pkg::BSR_W-1:0] ring_i,
    output logic [stp_pkg::BSR_W-1:0] ring_o,
    output logic extest_o,
    output logic q_oe_o
);
    // ------------------------------------------------------------
    // synchronise pins and find clock edges
    // ------------------------------------------------------------
    logic [2:0] pin_s;
    logic tck_d_reg;
    logic tck_d_next;
    logic tck_rise;
    logic tck_fall;

    stp_sync #(.W(3)) u_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .async_i({tck_i, tms_i, tdi_i}),
        .sync_o(pin_s)
    );

    // pin ring comes from the memory clock domain
    logic [stp_pkg::BSR_W-1:0] ring_s;

    stp_sync #(.W(stp_pkg::BSR_W)) u_ring_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .async_i(ring_i),
        .sync_o(ring_s)
    );

    // edge detector on the synchronised test clock
    always_comb begin
        tck_d_next = pin_s[2];
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            tck_d_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_d_next;
        end
    end

    assign tck_rise = pin_s[2] & ~tck_d_reg; // RL12
    assign tck_fall = ~pin_s[2] & tck_d_reg; // RL12

    // ------------------------------------------------------------
    // controller state
    // ------------------------------------------------------------
    stp_pkg::stp_state_t st_reg;
    stp_pkg::stp_state_t st_next;
    logic tms;

    assign tms = pin_s[1];

    // sixteen-state successor table
    always_comb begin
        st_next = st_reg;
        if (tck_rise) begin // RL1
            unique case (st_reg) // RL14
                stp_pkg::ST_RESET: begin
                    st_next = tms ? stp_pkg::ST_RESET : stp_pkg::ST_IDLE;
                end
                stp_pkg::ST_IDLE: begin
                    st_next = tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
                end
                stp_pkg::ST_SEL_DR: begin
                    st_next = tms ? stp_pkg::ST_SEL_IR : stp_pkg::ST_CAP_DR;
                end
                stp_pkg::ST_CAP_DR: begin
                    st_next = tms ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SH_DR;
                end
                stp_pkg::ST_SH_DR: begin
                    st_next = tms ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SH_DR;
                end
                stp_pkg::ST_EX1_DR: begin
                    st_next = tms ? stp_pkg::ST_UPD_DR : stp_pkg::ST_PAU_DR;
                end
                stp_pkg::ST_PAU_DR: begin
                    st_next = tms ? stp_pkg::ST_EX2_DR : stp_pkg::ST_PAU_DR;
                end
                stp_pkg::ST_EX2_DR: begin
                    st_next = tms ? stp_pkg::ST_UPD_DR : stp_pkg::ST_SH_DR;
                end
                stp_pkg::ST_UPD_DR: begin
                    st_next = tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
                end
                stp_pkg::ST_SEL_IR: begin
                    st_next = tms ? stp_pkg::ST_RESET : stp_pkg::ST_CAP_IR;
                end
                stp_pkg::ST_CAP_IR: begin
                    st_next = tms ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SH_IR;
                end
                stp_pkg::ST_SH_IR: begin
                    st_next = tms ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SH_IR;
                end
                stp_pkg::ST_EX1_IR: begin
                    st_next = tms ? stp_pkg::ST_UPD_IR : stp_pkg::ST_PAU_IR;
                end
                stp_pkg::ST_PAU_IR: begin
                    st_next = tms ? stp_pkg::ST_EX2_IR : stp_pkg::ST_PAU_IR;
                end
                stp_pkg::ST_EX2_IR: begin
                    st_next = tms ? stp_pkg::ST_UPD_IR : stp_pkg::ST_SH_IR;
                end
                stp_pkg::ST_UPD_IR: begin
                    st_next = tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // scan registers
    // ------------------------------------------------------------
    localparam logic [stp_pkg::ID_W-1:0] ID_WORD = {stp_pkg::ID_VERSION,
        stp_pkg::ID_PART, stp_pkg::ID_VENDOR, stp_pkg::ID_PRESENT};

    logic [stp_pkg::IR_W-1:0] ir_sh_reg, ir_sh_next;
    logic [stp_pkg::IR_W-1:0] ir_reg, ir_next;
    logic byp_reg, byp_next;
    logic [stp_pkg::ID_W-1:0] id_reg, id_next;
    logic [stp_pkg::BSR_W-1:0] bsr_reg, bsr_next;
    logic [stp_pkg::BSR_W-1:0] pre_reg, pre_next;
    logic tdo_reg, tdo_next;
    logic oe_reg, oe_next;
    logic tdi;
    logic use_bsr;
    logic ser;

    assign tdi = pin_s[0];
    // boundary chain serves external test, high-z sample, sample/preload
    assign use_bsr = (ir_reg == stp_pkg::INS_EXTEST) // RL6
        | (ir_reg == stp_pkg::INS_SAMPLE_Z) // RL3
        | (ir_reg == stp_pkg::INS_SAMPLE); // RL4

    // serial output selection
    always_comb begin
        if (st_reg == stp_pkg::ST_SH_IR) begin
            ser = ir_sh_reg[0];
        end else if (ir_reg == stp_pkg::INS_IDENT) begin
            ser = id_reg[0]; // RL2
        end else if (use_bsr) begin
            ser = bsr_reg[0];
        end else begin
            ser = byp_reg; // RL5
        end
    end

    // capture, shift and update on test clock edges
    always_comb begin
        ir_sh_next = ir_sh_reg;
        ir_next = ir_reg;
        byp_next = byp_reg;
        id_next = id_reg;
        bsr_next = bsr_reg;
        pre_next = pre_reg;
        tdo_next = tdo_reg;
        oe_next = oe_reg;
        if (tck_rise) begin
            unique case (st_reg)
                stp_pkg::ST_CAP_IR: begin
                    ir_sh_next = stp_pkg::IR_CAPTURE; // RL11
                end
                stp_pkg::ST_SH_IR: begin
                    ir_sh_next = {tdi, ir_sh_reg[stp_pkg::IR_W-1:1]};
                end
                stp_pkg::ST_UPD_IR: begin
                    ir_next = ir_sh_reg;
                end
                stp_pkg::ST_CAP_DR: begin
                    id_next = ID_WORD; // RL2 RL8 RL9
                    byp_next = 1'b0;
                    bsr_next = ring_s; // RL3 RL4 RL6
                end
                stp_pkg::ST_SH_DR: begin
                    if (ir_reg == stp_pkg::INS_IDENT) begin
                        id_next = {tdi, id_reg[stp_pkg::ID_W-1:1]};
                    end else if (use_bsr) begin
                        bsr_next = {tdi, bsr_reg[stp_pkg::BSR_W-1:1]};
                    end else begin
                        byp_next = tdi; // RL5
                    end
                end
                stp_pkg::ST_UPD_DR: begin
                    if (use_bsr) begin
                        pre_next = bsr_reg;
                    end
                end
                default: begin
                end
            endcase
        end
        // output changes on falling test clock only
        if (tck_fall) begin // RL12
            tdo_next = ser;
            oe_next = (st_reg == stp_pkg::ST_SH_IR)
                | (st_reg == stp_pkg::ST_SH_DR);
        end
        // reset state holds identify code and output-bus control, no edge
        if (st_reg == stp_pkg::ST_RESET) begin
            ir_next = stp_pkg::INS_IDENT; // RL10
            pre_next[stp_pkg::BSR_OE_BIT] = 1'b1; // RL13
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_reg <= stp_pkg::ST_RESET;
            ir_sh_reg <= '0;
            ir_reg <= stp_pkg::INS_IDENT; // RL10
            byp_reg <= 1'b0;
            id_reg <= '0;
            bsr_reg <= '0;
            pre_reg <= {1'b1, {(stp_pkg::BSR_W-1){1'b0}}};
            tdo_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ir_sh_reg <= ir_sh_next;
            ir_reg <= ir_next;
            byp_reg <= byp_next;
            id_reg <= id_next;
            bsr_reg <= bsr_next;
            pre_reg <= pre_next;
            tdo_reg <= tdo_next;
            oe_reg <= oe_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tdo_o = tdo_reg;
    assign tdo_oe_o = oe_reg;
    assign ring_o = pre_reg;
    assign extest_o = (ir_reg == stp_pkg::INS_EXTEST);
    // memory output enable: floated in high-z sample, cell 108 in extest
    assign q_oe_o = (ir_reg == stp_pkg::INS_SAMPLE_Z) ? 1'b0 // RL3
        : extest_o ? pre_reg[stp_pkg::BSR_OE_BIT] : 1'b1; // RL13
endmodule // stp_tap
